// ### pkg/pag_pkg.sv
/*
 * pag_pkg: shared constants for the parameter access guard.
 * Assumes parameter numbers fit in 10 bits and settings in 16 bits.
 */
package pag_pkg;

    // widths
    localparam int PAG_PW = 10;             // parameter number width
    localparam int PAG_DW = 16;             // setting width
    localparam int PAG_GRP_N = 16;          // user group capacity
    localparam int PAG_CW = 5;              // member count width

    // parameter numbers held locally, plus 501 which is always readable
    localparam logic [9:0] PAG_P_STOPKEY = 10'h04b;   // 75, stop key / reset select
    localparam logic [9:0] PAG_P_WPROT = 10'h04d;     // 77, write protect mode
    localparam logic [9:0] PAG_P_DIRLIM = 10'h04e;    // 78, direction limit
    localparam logic [9:0] PAG_P_RDSEL = 10'h0a0;     // 160, read restriction select
    localparam logic [9:0] PAG_P_GCOUNT = 10'h0ac;    // 172, group count / batch clear
    localparam logic [9:0] PAG_P_GADD = 10'h0ad;      // 173, group member add
    localparam logic [9:0] PAG_P_GREM = 10'h0ae;      // 174, group member remove
    localparam logic [9:0] PAG_P_ALWAYS_RD = 10'h1f5; // 501, always readable

    // setting codes
    localparam logic [15:0] PAG_V_NONE = 16'h270f;    // 9999
    localparam logic [15:0] PAG_V_PMAX = 16'h03e7;    // 999, highest parameter number
    localparam logic [15:0] PAG_WP_STOP = 16'h0000;   // write only at stop
    localparam logic [15:0] PAG_WP_LOCK = 16'h0001;   // writes refused
    localparam logic [15:0] PAG_WP_ANY = 16'h0002;    // writes while running
    localparam logic [15:0] PAG_DL_BOTH = 16'h0000;   // both directions
    localparam logic [15:0] PAG_DL_NOREV = 16'h0001;  // reverse blocked
    localparam logic [15:0] PAG_DL_NOFWD = 16'h0002;  // forward blocked
    localparam logic [15:0] PAG_RS_FULL = 16'h0000;   // simple + extended
    localparam logic [15:0] PAG_RS_GROUP = 16'h0001;  // group members only
    localparam logic [15:0] PAG_RS_SIMPLE = PAG_V_NONE; // simple only

    // reset values
    localparam logic [15:0] PAG_RST_WPROT = 16'h0000;
    localparam logic [15:0] PAG_RST_DIRLIM = 16'h0000;
    localparam logic [15:0] PAG_RST_RDSEL = 16'h0000;
    localparam logic [15:0] PAG_RST_STOPKEY = 16'h000e;   // 14

    // answer kinds
    typedef enum logic [1:0] {PAG_ANS_OK, PAG_ANS_REJ, PAG_ANS_IDLE} pag_ans_type;

endpackage : pag_pkg

// ### hdl/pag_guard.sv
/*
 * pag_guard: parameter access guard of a motor drive.
 * Holds the protect, direction, read-select, stop-key and user group
 * settings and judges every read, write and clear request.
 * Assumes requests are single-cycle strobes synchronous to i_clk, and that
 * the parameter store outside writes only on o_wr_go.
 */
// Summary of operation
// - mode 0 writes while stopped, or anytime-flagged targets while running
// - mode 1 refuses ordinary writes, reads allowed
// - mode 2 writes anytime except run-locked
// - mode 1 refuses parameter and all clears
// - mode 1 still writes 22,75,77,160,296,297
// - mode 0 run writes 72,240,275 panel only
// - mode 2 run-locked list refused while running
// - protect mode writable anytime, never from network
// - direction limit 0 both,1 no reverse,2 no forward
// - direction limit overrides panel and network runs
// - read select 9999 simple,0 all,1 group
// - count reads members; 9999 write clears all
// - add/remove entries edit group, read 9999
// - group parameters writable only when select 0
// - protect, direction, select writable only when 0
// - parameter 501 always readable
// - network reads see every parameter
// - read select writable while running, modes 0,1
// - stop-key setting survives parameter clears
// - protect/select/group params never members; first two readable
`timescale 1ns/1ps

module pag_guard
    import pag_pkg::*;
(
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    // drive status
    input  wire logic        i_running,       // motor drive running
    // parameter request
    input  wire logic        i_req,           // one-cycle request strobe
    input  wire logic        i_req_wr,        // 1 write, 0 read
    input  wire logic        i_req_net,       // 1 network link, 0 local panel
    input  wire logic [9:0]  i_req_num,       // parameter number
    input  wire logic [15:0] i_req_wdata,     // value to write
    input  wire logic        i_req_simple,    // target is a simple mode parameter
    input  wire logic        i_req_anytime,   // target is writable anytime in mode 0
    // clear commands
    input  wire logic        i_clr,           // parameter clear strobe
    input  wire logic        i_allclr,        // all-parameter clear strobe
    // run commands in
    input  wire logic        i_run_fwd,
    input  wire logic        i_run_rev,
    // answer
    output logic             o_ack,           // answer strobe
    output logic             o_rej,           // request refused
    output logic [15:0]      o_rdata,         // read data for local settings
    output logic             o_wr_go,         // external store may write
    output logic             o_clr_go,        // external clear may run
    output logic             o_clr_rej,       // clear refused
    // run commands out
    output logic             o_run_fwd,
    output logic             o_run_rev
);

    // local settings
    logic [15:0]       wprot_r;            // write_protect_mode
    logic [15:0]       dirlim_r;           // direction_limit
    logic [15:0]       rdsel_r;            // read_restriction_select
    logic [15:0]       stopkey_r;          // stop_key_reset_select
    logic [9:0]        grp_num_r [PAG_GRP_N]; // group member numbers
    logic [15:0]       grp_vld_r;          // member valid bits

    // decisions for the current request
    logic              local_hit;          // target held in this block
    logic              wr_ok;              // write permitted
    logic              val_ok;             // written value in range
    logic              rd_ok;              // read permitted
    logic              clr_ok;             // clear permitted
    logic              do_wr;              // accepted write this cycle
    logic [4:0]        grp_cnt;            // combinational member count
    logic [15:0]       rd_val;             // local read value

    // membership lookup, used for reads and for add
    function automatic logic grp_has(input logic [9:0] num,
                                     input logic [9:0] tab [PAG_GRP_N],
                                     input logic [15:0] vld);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < PAG_GRP_N; k++)
        begin
            if (vld[k] && tab[k] == num)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : grp_has

    // parameters that may not join the group
    function automatic logic grp_barred(input logic [9:0] num);
        return num == PAG_P_WPROT || num == PAG_P_RDSEL || num == PAG_P_GCOUNT ||
               num == PAG_P_GADD || num == PAG_P_GREM;
    endfunction : grp_barred

    // write permission for a number under the current settings
    function automatic logic wr_permit(input logic [9:0] num,
                                       input logic [15:0] wp,
                                       input logic [15:0] rs,
                                       input logic run,
                                       input logic net,
                                       input logic anytime);
        logic ok;
        logic lock_list;
        logic run_locked;
        logic carrier;
        logic panel_run;
        // writable even when locked
        lock_list = num == 10'd22 || num == PAG_P_STOPKEY || num == PAG_P_WPROT ||
                    num == PAG_P_RDSEL || num == 10'd296 || num == 10'd297;
        // refused while running in mode 2
        run_locked = num == 10'd23 || num == 10'd40 || num == 10'd48 ||
                     num == 10'd60 || num == 10'd61 || num == 10'd66 ||
                     num == 10'd71 || (num >= 10'd80 && num <= 10'd84) ||
                     (num >= 10'd90 && num <= 10'd94) || num == 10'd96 ||
                     num == 10'd277 || num == 10'd292 || num == 10'd293 ||
                     num == 10'd298 || num == 10'd450 || num == 10'd800 ||
                     num == 10'd859;
        // carrier-type settings: running writes in mode 0 from panel only, even if flagged anytime
        carrier = num == 10'd72 || num == 10'd240 || num == 10'd275;
        panel_run = carrier && !net;
        if (wp == PAG_WP_LOCK)
        begin
            ok = lock_list;
        end
        else if (wp == PAG_WP_ANY)
        begin
            ok = !(run && run_locked);
        end
        else
        begin
            // stop key and read select also change while running
            // anytime flag never lets a network write reach a carrier setting
            ok = !run || (anytime && !carrier) || panel_run || num == PAG_P_STOPKEY ||
                 num == PAG_P_RDSEL;
        end
        // protect mode: any state, never over the network
        if (num == PAG_P_WPROT)
        begin
            ok = !net;
        end
        // settings gated by the read select
        if ((num == PAG_P_WPROT || num == PAG_P_DIRLIM || num == PAG_P_RDSEL ||
             num == PAG_P_GCOUNT || num == PAG_P_GADD || num == PAG_P_GREM) &&
            rs != PAG_RS_FULL)
        begin
            ok = 1'b0;
        end
        return ok;
    endfunction : wr_permit

    // member count
    always_comb
    begin
        grp_cnt = '0;
        for (int k = 0; k < PAG_GRP_N; k++)
        begin
            grp_cnt = grp_cnt + PAG_CW'(grp_vld_r[k]);
        end
    end

    // request decoding
    always_comb
    begin
        local_hit = i_req_num == PAG_P_STOPKEY || i_req_num == PAG_P_WPROT ||
                    i_req_num == PAG_P_DIRLIM || i_req_num == PAG_P_RDSEL ||
                    i_req_num == PAG_P_GCOUNT || i_req_num == PAG_P_GADD ||
                    i_req_num == PAG_P_GREM;
        wr_ok = wr_permit(i_req_num, wprot_r, rdsel_r, i_running, i_req_net,
                          i_req_anytime);
        // value range of local settings; out of range is refused
        unique case (i_req_num)
            PAG_P_WPROT, PAG_P_DIRLIM: val_ok = i_req_wdata <= PAG_WP_ANY;
            PAG_P_RDSEL: val_ok = i_req_wdata == PAG_RS_FULL ||
                                  i_req_wdata == PAG_RS_GROUP ||
                                  i_req_wdata == PAG_RS_SIMPLE;
            PAG_P_GADD, PAG_P_GREM: val_ok = i_req_wdata <= PAG_V_PMAX ||
                                             i_req_wdata == PAG_V_NONE;
            default: val_ok = 1'b1;
        endcase
        // read permission
        if (i_req_net || i_req_num == PAG_P_ALWAYS_RD)
        begin
            rd_ok = 1'b1;
        end
        else if (i_req_num == PAG_P_WPROT || i_req_num == PAG_P_RDSEL)
        begin
            rd_ok = 1'b1;
        end
        else if (rdsel_r == PAG_RS_SIMPLE)
        begin
            rd_ok = i_req_simple;
        end
        else if (rdsel_r == PAG_RS_GROUP)
        begin
            rd_ok = grp_has(i_req_num, grp_num_r, grp_vld_r);
        end
        else
        begin
            rd_ok = 1'b1;
        end
        clr_ok = wprot_r != PAG_WP_LOCK;
        do_wr = i_ce && i_req && i_req_wr && wr_ok && val_ok;
        // local read values; add/remove always read back 9999
        unique case (i_req_num)
            PAG_P_STOPKEY: rd_val = stopkey_r;
            PAG_P_WPROT: rd_val = wprot_r;
            PAG_P_DIRLIM: rd_val = dirlim_r;
            PAG_P_RDSEL: rd_val = rdsel_r;
            PAG_P_GCOUNT: rd_val = {11'h000, grp_cnt};
            PAG_P_GADD, PAG_P_GREM: rd_val = PAG_V_NONE;
            default: rd_val = 16'h0000;
        endcase
    end

    // answer to requests, one cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_ack <= 1'b0;
            o_rej <= 1'b0;
            o_rdata <= 16'h0000;
            o_wr_go <= 1'b0;
        end
        else if (i_ce)
        begin
            o_ack <= i_req;
            o_rej <= i_req && (i_req_wr ? !(wr_ok && val_ok) : !rd_ok);
            // store only told for targets it owns
            o_wr_go <= do_wr && !local_hit;
            if (i_req && !i_req_wr && rd_ok)
            begin
                o_rdata <= rd_val;
            end
        end
    end

    // clear commands; a clear wins over a local setting write in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_clr_go <= 1'b0;
            o_clr_rej <= 1'b0;
        end
        else if (i_ce)
        begin
            o_clr_go <= (i_clr || i_allclr) && clr_ok;
            o_clr_rej <= (i_clr || i_allclr) && !clr_ok;
        end
    end

    // scalar settings
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            wprot_r <= PAG_RST_WPROT;
            dirlim_r <= PAG_RST_DIRLIM;
            rdsel_r <= PAG_RST_RDSEL;
            stopkey_r <= PAG_RST_STOPKEY;
        end
        else if (i_ce)
        begin
            if ((i_clr || i_allclr) && clr_ok)
            begin
                // stop key kept on purpose so a clear cannot disarm the stop
                dirlim_r <= PAG_RST_DIRLIM;
                rdsel_r <= PAG_RST_RDSEL;
                if (i_allclr)
                begin
                    wprot_r <= PAG_RST_WPROT;
                end
            end
            else if (do_wr)
            begin
                unique case (i_req_num)
                    PAG_P_WPROT: wprot_r <= i_req_wdata;
                    PAG_P_DIRLIM: dirlim_r <= i_req_wdata;
                    PAG_P_RDSEL: rdsel_r <= i_req_wdata;
                    PAG_P_STOPKEY: stopkey_r <= i_req_wdata;
                    default: ;
                endcase
            end
        end
    end

    // user group table
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            grp_vld_r <= 16'h0000;
            for (int k = 0; k < PAG_GRP_N; k++)
            begin
                grp_num_r[k] <= 10'h000;
            end
        end
        else if (i_ce)
        begin
            if ((i_clr || i_allclr) && clr_ok)
            begin
                grp_vld_r <= 16'h0000;
            end
            else if (do_wr && i_req_num == PAG_P_GCOUNT && i_req_wdata == PAG_V_NONE)
            begin
                grp_vld_r <= 16'h0000;
            end
            else if (do_wr && i_req_num == PAG_P_GADD && i_req_wdata <= PAG_V_PMAX &&
                     !grp_barred(i_req_wdata[9:0]) &&
                     !grp_has(i_req_wdata[9:0], grp_num_r, grp_vld_r))
            begin
                // first free slot; a full group drops the add silently
                for (int k = PAG_GRP_N - 1; k >= 0; k--)
                begin
                    if (!grp_vld_r[k])
                    begin
                        grp_num_r[k] <= i_req_wdata[9:0];
                    end
                end
                grp_vld_r <= grp_vld_r | (~grp_vld_r & (grp_vld_r + 16'h0001));
            end
            else if (do_wr && i_req_num == PAG_P_GREM && i_req_wdata <= PAG_V_PMAX)
            begin
                for (int k = 0; k < PAG_GRP_N; k++)
                begin
                    if (grp_num_r[k] == i_req_wdata[9:0])
                    begin
                        grp_vld_r[k] <= 1'b0;
                    end
                end
            end
        end
    end

    // direction limiter, last stage before the drive
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_run_fwd <= 1'b0;
            o_run_rev <= 1'b0;
        end
        else if (i_ce)
        begin
            o_run_fwd <= i_run_fwd && dirlim_r != PAG_DL_NOFWD;
            o_run_rev <= i_run_rev && dirlim_r != PAG_DL_NOREV;
        end
    end

    // checks
    a_lock_blocks_wr: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_req && i_req_wr && wprot_r == PAG_WP_LOCK && i_req_num != 10'd22 &&
        i_req_num != PAG_P_STOPKEY && i_req_num != PAG_P_WPROT &&
        i_req_num != PAG_P_RDSEL && i_req_num != 10'd296 && i_req_num != 10'd297
        |=> o_rej && !o_wr_go)
        else $error("write accepted while protect mode locked");
    a_net_carrier: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_req && i_req_wr && i_req_net && i_running && wprot_r == PAG_WP_STOP &&
        (i_req_num == 10'd72 || i_req_num == 10'd240 || i_req_num == 10'd275)
        |=> o_rej && !o_wr_go)
        else $error("network carrier write accepted while running");
    a_stop_wr_run: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_req && i_req_wr && wprot_r == PAG_WP_STOP && i_running &&
        !i_req_anytime && !local_hit && i_req_num != 10'd72 && i_req_num != 10'd240 &&
        i_req_num != 10'd275 |=> o_rej)
        else $error("running write accepted in mode 0");
    a_net_wprot: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_req && i_req_wr && i_req_net && i_req_num == PAG_P_WPROT
        |=> o_rej && $stable(wprot_r))
        else $error("protect mode changed over network");
    a_clear_locked: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && (i_clr || i_allclr) && wprot_r == PAG_WP_LOCK |=> o_clr_rej && !o_clr_go)
        else $error("clear run in locked mode");
    a_stopkey_kept: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && (i_clr || i_allclr) |=> $stable(stopkey_r))
        else $error("stop key setting lost on clear");
    a_rev_blocked: assert property (@(posedge i_clk) disable iff (!i_nrst)
        dirlim_r == PAG_DL_NOREV ##1 1'b1 |-> !o_run_rev || $past(i_ce) == 1'b0)
        else $error("reverse driven while blocked");
    a_fwd_blocked: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && dirlim_r == PAG_DL_NOFWD |=> !o_run_fwd)
        else $error("forward driven while blocked");
    a_net_read_ok: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_req && !i_req_wr && i_req_net |=> o_ack && !o_rej)
        else $error("network read refused");
    a_add_reads_none: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_req && !i_req_wr && rd_ok && i_req_num == PAG_P_GADD
        |=> o_rdata == PAG_V_NONE)
        else $error("add entry did not read 9999");
    a_batch_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
        do_wr && i_req_num == PAG_P_GCOUNT && i_req_wdata == PAG_V_NONE |=> grp_cnt == 5'd0)
        else $error("batch clear left members");

endmodule : pag_guard

// ### dv/pag_host_model.sv
/*
 * pag_host_model: panel and network master issuing parameter requests.
 * Assumes the guard takes a request on a rising edge and answers on that same edge.
 */
`timescale 1ns/1ps

module pag_host_model
(
    // clock
    input  wire logic        i_clk,
    // request out
    output logic             o_req,
    output logic             o_req_wr,
    output logic             o_req_net,
    output logic             o_req_simple,
    output logic             o_req_anytime,
    output logic [9:0]       o_req_num,
    output logic [15:0]      o_req_wdata
);
    // idle at time zero
    initial
    begin
        o_req         = 1'b0;
        o_req_wr      = 1'b0;
        o_req_net     = 1'b0;
        o_req_simple  = 1'b0;
        o_req_anytime = 1'b0;
        o_req_num     = 10'h3ff;
        o_req_wdata   = 16'hffff;
    end

    // one request held through the taking edge; number and data then inverted
    // so nothing downstream can lean on stale values
    task automatic acc(input logic wr, net, smp, any, input logic [9:0] num,
                       input logic [15:0] dat);
        @(posedge i_clk);
        o_req         <= 1'b1;
        o_req_wr      <= wr;
        o_req_net     <= net;
        o_req_simple  <= smp;
        o_req_anytime <= any;
        o_req_num     <= num;
        o_req_wdata   <= dat;
        @(posedge i_clk);
        o_req         <= 1'b0;
        o_req_num     <= ~num;
        o_req_wdata   <= ~dat;
        #1;
    endtask : acc
endmodule : pag_host_model

// ### dv/tb.sv
/*
 * tb: self-checking bench of pag_guard.
 * Assumes the host model answers settle 1 ns after the answering edge.
 */
`timescale 1ns/1ps

module tb;
    import pag_pkg::*;
    localparam logic RD = 1'b0, WR = 1'b1, PNL = 1'b0, NET = 1'b1;
    logic        clk, nrst, ce, running, clr_s, allclr, run_fwd, run_rev;
    logic        f_smp, f_any;            // target class of next request
    int          n_fail, compares;
    wire logic   req, req_wr, req_net, req_simple, req_anytime;
    wire logic [9:0]  req_num;
    wire logic [15:0] req_wdata, rdata;
    wire logic   ack, rej, wr_go, clr_go, clr_rej, o_fwd, o_rev;
    // run-locked numbers in mode 2
    logic [9:0]  lock [25] = '{10'h017, 10'h028, 10'h030, 10'h03c, 10'h03d,
        10'h042, 10'h047, 10'h050, 10'h051, 10'h052, 10'h053, 10'h054, 10'h05a,
        10'h05b, 10'h05c, 10'h05d, 10'h05e, 10'h060, 10'h115, 10'h124, 10'h125,
        10'h12a, 10'h1c2, 10'h320, 10'h35b};

    pag_host_model u_pag_host_model (.i_clk(clk), .o_req(req), .o_req_wr(req_wr),
        .o_req_net(req_net), .o_req_simple(req_simple), .o_req_anytime(req_anytime),
        .o_req_num(req_num), .o_req_wdata(req_wdata));
    pag_guard u_pag_guard (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_running(running),
        .i_req(req), .i_req_wr(req_wr), .i_req_net(req_net), .i_req_num(req_num),
        .i_req_wdata(req_wdata), .i_req_simple(req_simple), .i_req_anytime(req_anytime),
        .i_clr(clr_s), .i_allclr(allclr), .i_run_fwd(run_fwd), .i_run_rev(run_rev),
        .o_ack(ack), .o_rej(rej), .o_rdata(rdata), .o_wr_go(wr_go), .o_clr_go(clr_go),
        .o_clr_rej(clr_rej), .o_run_fwd(o_fwd), .o_run_rev(o_rev));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // comparison helpers
    task automatic chk(input string nm, input logic [15:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic chkb(input string nm, input logic got, exp);
        chk(nm, {15'h0000, got}, {15'h0000, exp});
    endtask : chkb
    // one request, answer strobe and refusal judged
    task automatic rq(input logic wr, net, input logic [9:0] num,
                      input logic [15:0] dat, input logic exp_rej);
        u_pag_host_model.acc(wr, net, f_smp, f_any, num, dat);
        chkb("ack", ack, 1'b1);
        chkb("rej", rej, exp_rej);
    endtask : rq
    task automatic rd(input logic [9:0] num, input logic [15:0] exp);
        rq(RD, PNL, num, 16'h0000, 1'b0);
        chk("rdata", rdata, exp);
    endtask : rd
    task automatic set_run(input logic v);
        @(posedge clk);
        running <= v;
    endtask : set_run
    // clear strobe, one-cycle verdict after it
    task automatic clr(input logic all, exp_rej);
        @(posedge clk);
        if (all) allclr <= 1'b1;
        else clr_s <= 1'b1;
        @(posedge clk);
        allclr <= 1'b0;
        clr_s  <= 1'b0;
        #1;
        chkb("clr_go", clr_go, !exp_rej);
        chkb("clr_rej", clr_rej, exp_rej);
    endtask : clr

    task automatic t_reset;
        rd(PAG_P_WPROT, PAG_RST_WPROT);
        rd(PAG_P_DIRLIM, PAG_DL_BOTH);
        rd(PAG_P_RDSEL, PAG_RS_FULL);
        rd(PAG_P_GCOUNT, 16'h0000);
        rd(PAG_P_GREM, PAG_V_NONE);
    endtask : t_reset
    task automatic t_mode0;
        set_run(1'b1);
        rq(WR, PNL, 10'h064, 16'h0005, 1'b1);
        chkb("wr_go", wr_go, 1'b0);
        f_any = 1'b1;
        rq(WR, PNL, 10'h048, 16'h0002, 1'b0);
        rq(WR, NET, 10'h0f0, 16'h0001, 1'b1);
        rq(WR, NET, 10'h113, 16'h0001, 1'b1);
        f_any = 1'b0;
        rq(WR, PNL, PAG_P_RDSEL, PAG_RS_FULL, 1'b0);
        set_run(1'b0);
        rq(WR, PNL, 10'h064, 16'h0005, 1'b0);
        chkb("wr_go", wr_go, 1'b1);
    endtask : t_mode0
    task automatic t_dir;
        for (int v = 0; v < 3; v++)
        begin
            rq(WR, PNL, PAG_P_DIRLIM, 16'(v), 1'b0);
            repeat (2) @(posedge clk);
            #1;
            chkb("run_fwd", o_fwd, v != 2);
            chkb("run_rev", o_rev, v != 1);
        end
        rq(WR, PNL, PAG_P_DIRLIM, 16'h0003, 1'b1);
        rd(PAG_P_DIRLIM, PAG_DL_NOFWD);
    endtask : t_dir
    // clock enable low: a request is ignored and no setting moves
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        u_pag_host_model.acc(WR, PNL, f_smp, f_any, PAG_P_DIRLIM, PAG_DL_BOTH);
        chkb("ack frozen", ack, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        rd(PAG_P_DIRLIM, PAG_DL_NOFWD);
    endtask : t_freeze
    task automatic t_mode1;
        rq(WR, PNL, PAG_P_WPROT, PAG_WP_LOCK, 1'b0);
        rq(WR, PNL, 10'h064, 16'h0001, 1'b1);
        chkb("wr_go", wr_go, 1'b0);
        rq(RD, PNL, 10'h064, 16'h0000, 1'b0);
        rq(WR, PNL, PAG_P_STOPKEY, 16'h0003, 1'b0);
        rq(WR, PNL, 10'h016, 16'h0001, 1'b0);
        chkb("wr_go", wr_go, 1'b1);
        rq(WR, PNL, 10'h129, 16'h0000, 1'b0);
        clr(1'b0, 1'b1);
        clr(1'b1, 1'b1);
        rq(WR, NET, PAG_P_WPROT, PAG_WP_ANY, 1'b1);
        set_run(1'b1);
        rq(WR, PNL, PAG_P_WPROT, PAG_WP_ANY, 1'b0);
    endtask : t_mode1
    task automatic t_mode2;
        foreach (lock[i]) rq(WR, PNL, lock[i], 16'h0001, 1'b1);
        rq(WR, PNL, 10'h064, 16'h0001, 1'b0);
        set_run(1'b0);
        rq(WR, PNL, 10'h017, 16'h0001, 1'b0);
    endtask : t_mode2
    task automatic t_group;
        rq(WR, PNL, PAG_P_GADD, 16'h0003, 1'b0);
        rq(WR, PNL, PAG_P_GADD, {6'h00, PAG_P_WPROT}, 1'b0);
        rd(PAG_P_GCOUNT, 16'h0001);
        rd(PAG_P_GADD, PAG_V_NONE);
        rq(WR, PNL, PAG_P_RDSEL, PAG_RS_GROUP, 1'b0);
        rq(RD, PNL, 10'h003, 16'h0000, 1'b0);
        rq(RD, PNL, 10'h064, 16'h0000, 1'b1);
        rq(RD, PNL, PAG_P_ALWAYS_RD, 16'h0000, 1'b0);
        rd(PAG_P_WPROT, PAG_WP_ANY);
        rq(RD, NET, 10'h064, 16'h0000, 1'b0);
        rq(WR, PNL, PAG_P_GADD, 16'h0005, 1'b1);
        rq(WR, PNL, PAG_P_DIRLIM, 16'h0000, 1'b1);
        clr(1'b0, 1'b0);
        rd(PAG_P_DIRLIM, PAG_DL_BOTH);
        rd(PAG_P_STOPKEY, 16'h0003);
        rq(WR, PNL, PAG_P_RDSEL, PAG_RS_SIMPLE, 1'b0);
        rq(RD, PNL, 10'h064, 16'h0000, 1'b1);
        f_smp = 1'b1;
        rq(RD, PNL, 10'h064, 16'h0000, 1'b0);
        f_smp = 1'b0;
        clr(1'b0, 1'b0);
        for (int i = 0; i < 17; i++) rq(WR, PNL, PAG_P_GADD, 16'h0064 + 16'(i), 1'b0);
        rd(PAG_P_GCOUNT, 16'h0010);
        rq(WR, PNL, PAG_P_GREM, 16'h0064, 1'b0);
        rq(WR, PNL, PAG_P_GCOUNT, 16'h0005, 1'b0);
        rd(PAG_P_GCOUNT, 16'h000f);
        rq(WR, PNL, PAG_P_GCOUNT, PAG_V_NONE, 1'b0);
        rd(PAG_P_GCOUNT, 16'h0000);
        clr(1'b1, 1'b0);
        rd(PAG_P_WPROT, PAG_RST_WPROT);
        rd(PAG_P_STOPKEY, 16'h0003);
    endtask : t_group

    // verdict, the one place the run ends
    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        {nrst, running, clr_s, allclr, f_smp, f_any} = 6'h00;
        {ce, run_fwd, run_rev} = 3'h7;
        n_fail = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_mode0();
        t_dir();
        t_freeze();
        t_mode1();
        t_mode2();
        t_group();
        tally_and_finish();
    end
endmodule : tb
